/* power_reference_pkg.sv */
// Register map, field positions and reset values of the power and reference control bank
package power_reference_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;

   localparam logic [7:0] OFS_POWER_CONTROL_ONE = 8'h01;
   localparam logic [7:0] OFS_POWER_CONTROL_TWO = 8'h02;
   localparam logic [7:0] OFS_SOFT_RAMP_CONTROL = 8'h39;

   // power_control_one fields
   localparam int unsigned BIT_SPEAKER_OUT_EN  = 12;
   localparam int unsigned BIT_HP_LEFT_STAGE   = 9;
   localparam int unsigned BIT_HP_RIGHT_STAGE  = 8;
   localparam int unsigned BIT_DIV_SEL_HI      = 2;
   localparam int unsigned BIT_DIV_SEL_LO      = 1;
   localparam int unsigned BIT_MAIN_BIAS       = 0;

   // power_control_two fields
   localparam int unsigned BIT_OVER_TEMP       = 15;
   localparam int unsigned BIT_THERMAL_SENSOR  = 14;
   localparam int unsigned BIT_THERMAL_CUTOFF  = 13;
   localparam int unsigned BIT_FIRST_IN_A      = 7;
   localparam int unsigned BIT_FIRST_IN_B      = 6;
   localparam int unsigned BIT_SECOND_IN_A     = 5;

   // soft_ramp_control fields
   localparam int unsigned BIT_REF_RAMP_EN     = 0;

   // Writable masks; other positions read zero, except the over-temperature status bit 15 of 02h
   localparam logic [15:0] MASK_ONE  = 16'h1307;
   localparam logic [15:0] MASK_TWO  = 16'h60e0;
   localparam logic [15:0] MASK_RAMP = 16'h0001;

   localparam logic [15:0] RST_ONE   = 16'h0006;
   localparam logic [15:0] RST_TWO   = 16'h2000;
   localparam logic [15:0] RST_RAMP  = 16'h0000;

   typedef enum logic [1:0] {
      DIV_OFF      = 2'h0,
      DIV_NORMAL   = 2'h1,
      DIV_STANDBY  = 2'h2,
      DIV_FAST     = 2'h3
   } ref_divider_t;

   typedef enum logic [3:0] {
      SEL_NONE     = 4'h1,
      SEL_NORMAL   = 4'h2,
      SEL_STANDBY  = 4'h4,
      SEL_FAST     = 4'h8
   } divider_onehot_t;

endpackage : power_reference_pkg

/* power_reference_control_regs.sv */
// Power, reference and thermal control register bank
`timescale 1ns/100ps

module power_reference_control_regs #(
   parameter int unsigned RAMP_STEPS = 256
) (
   input  wire logic                                    clk,
   input  wire logic                                    sys_rst,
   input  wire logic                                    reg_wr,
   input  wire logic [power_reference_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [power_reference_pkg::DATA_W-1:0]  reg_wdata,
   output logic      [power_reference_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic                                    over_temp,
   output logic      [1:0]                              ref_divider_select,
   output logic      [3:0]                              divider_onehot,
   output logic                                         ref_ramp_enable,
   output logic      [7:0]                              midrail_ramp_level,
   output logic                                         main_bias_enable,
   output logic                                         speaker_out_enable,
   output logic                                         hp_left_stage_enable,
   output logic                                         hp_right_stage_enable,
   output logic                                         thermal_sensor_enable,
   output logic                                         thermal_output_cutoff,
   output logic                                         outputs_disabled,
   output logic                                         first_input_a_amp_enable,
   output logic                                         first_input_b_amp_enable,
   output logic                                         second_input_a_amp_enable
);
   import power_reference_pkg::*;

   localparam logic [7:0] RAMP_TOP = 8'hff;
   // Level steps span the full 8-bit range of the ramp output
   localparam int unsigned LEVEL_SPAN = 256;

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [15:0] one_q, one_d;
   logic [15:0] two_q, two_d;
   logic [15:0] ramp_q, ramp_d;
   logic [7:0]  level_q, level_d;
   logic        hot_q, hot_d;
   logic [7:0]  ramp_cnt_q, ramp_cnt_d;
   logic [7:0]  step_div;
   logic        pace_tick;
   logic        hit_one, hit_two, hit_ramp;
   logic [15:0] two_status;

   // Pacing rounds down: below one full span of steps the level climbs once per clock
   assign step_div  = 8'(RAMP_STEPS / LEVEL_SPAN);
   assign pace_tick = (ramp_cnt_q >= step_div);

   // One address compare per register keeps the write decode readable
   assign hit_one  = reg_wr && (reg_addr == OFS_POWER_CONTROL_ONE);
   assign hit_two  = reg_wr && (reg_addr == OFS_POWER_CONTROL_TWO);
   assign hit_ramp = reg_wr && (reg_addr == OFS_SOFT_RAMP_CONTROL);

   always_comb begin
      one_d  = one_q;
      two_d  = two_q;
      ramp_d = ramp_q;
      // Masks drop undocumented bits on the way in, so the read path needs no mask
      if (hit_one) begin
         one_d = reg_wdata & MASK_ONE;
      end else if (hit_two) begin
         two_d = reg_wdata & MASK_TWO;
      end else if (hit_ramp) begin
         ramp_d = reg_wdata & MASK_RAMP;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         one_q  <= RST_ONE;
         two_q  <= RST_TWO;
         ramp_q <= RST_RAMP;
      end else begin
         one_q  <= one_d;
         two_q  <= two_d;
         ramp_q <= ramp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path; undocumented bits already zero in storage

   // Status bit is not stored, so a write to 02h can never set it
   always_comb begin
      two_status                = two_q;
      two_status[BIT_OVER_TEMP] = hot_q;
   end

   always_comb begin
      if (reg_addr == OFS_POWER_CONTROL_ONE) begin
         reg_rdata = one_q;
      end else if (reg_addr == OFS_POWER_CONTROL_TWO) begin
         reg_rdata = two_status;
      end else if (reg_addr == OFS_SOFT_RAMP_CONTROL) begin
         reg_rdata = ramp_q;
      end else begin
         reg_rdata = 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reference soft ramp: level climbs one step per interval instead of jumping

   always_comb begin
      level_d    = level_q;
      ramp_cnt_d = ramp_cnt_q;
      if (!ramp_q[BIT_REF_RAMP_EN]) begin
         level_d    = 8'h00;
         ramp_cnt_d = 8'h00;
      end else if (level_q != RAMP_TOP) begin
         // Climb one step per pacing interval, never a jump
         if (pace_tick) begin
            ramp_cnt_d = 8'h00;
            level_d    = level_q + 8'h01;
         end else begin
            ramp_cnt_d = ramp_cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_q    <= 8'h00;
         ramp_cnt_q <= 8'h00;
      end else begin
         level_q    <= level_d;
         ramp_cnt_q <= ramp_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Over-temperature status, sampled only while the sensor runs
   // Not sticky: the bit follows the sensor, so software must poll it

   always_comb begin
      hot_d = two_q[BIT_THERMAL_SENSOR] & over_temp;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hot_q <= 1'b0;
      end else begin
         hot_q <= hot_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and outputs

   // Decode and gating use next-state values so the pins change on the same edge as the
   // registers they follow, and come straight from flip-flops without decode glitches
   logic [3:0] onehot_q, onehot_d;
   logic       cut_q, cut_d;
   logic       speaker_q, speaker_d;
   logic       hp_left_q, hp_left_d;
   logic       hp_right_q, hp_right_d;

   always_comb begin
      case (one_d[BIT_DIV_SEL_HI:BIT_DIV_SEL_LO])
         DIV_OFF:     onehot_d = SEL_NONE;
         DIV_NORMAL:  onehot_d = SEL_NORMAL;
         DIV_STANDBY: onehot_d = SEL_STANDBY;
         default:     onehot_d = SEL_FAST;
      endcase
      // Cutoff needs the cutoff bit, the sensor bit and a raised over_temp
      cut_d      = hot_d & two_d[BIT_THERMAL_CUTOFF];
      speaker_d  = one_d[BIT_SPEAKER_OUT_EN] & ~cut_d;
      hp_left_d  = one_d[BIT_HP_LEFT_STAGE] & ~cut_d;
      hp_right_d = one_d[BIT_HP_RIGHT_STAGE] & ~cut_d;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Must agree with the divider reset of fast start-up
         onehot_q   <= SEL_FAST;
         cut_q      <= 1'b0;
         speaker_q  <= 1'b0;
         hp_left_q  <= 1'b0;
         hp_right_q <= 1'b0;
      end else begin
         onehot_q   <= onehot_d;
         cut_q      <= cut_d;
         speaker_q  <= speaker_d;
         hp_left_q  <= hp_left_d;
         hp_right_q <= hp_right_d;
      end
   end

   assign divider_onehot            = onehot_q;
   assign outputs_disabled          = cut_q;
   assign ref_divider_select        = one_q[BIT_DIV_SEL_HI:BIT_DIV_SEL_LO];
   assign ref_ramp_enable           = ramp_q[BIT_REF_RAMP_EN];
   assign midrail_ramp_level        = level_q;
   assign main_bias_enable          = one_q[BIT_MAIN_BIAS];
   assign speaker_out_enable        = speaker_q;
   assign hp_left_stage_enable      = hp_left_q;
   assign hp_right_stage_enable     = hp_right_q;
   assign thermal_sensor_enable     = two_q[BIT_THERMAL_SENSOR];
   assign thermal_output_cutoff     = two_q[BIT_THERMAL_CUTOFF];
   assign first_input_a_amp_enable  = two_q[BIT_FIRST_IN_A];
   assign first_input_b_amp_enable  = two_q[BIT_FIRST_IN_B];
   assign second_input_a_amp_enable = two_q[BIT_SECOND_IN_A];

endmodule : power_reference_control_regs

/* power_reference_control_regs_asserts.sv */
// Property checker for the power and reference control bank
`timescale 1ns/100ps
module power_reference_control_regs_asserts (
   input logic        clk,
   input logic        sys_rst,
   input logic        reg_wr,
   input logic [7:0]  reg_addr,
   input logic [15:0] reg_wdata,
   input logic        over_temp,
   input logic [1:0]  ref_divider_select,
   input logic [3:0]  divider_onehot,
   input logic        ref_ramp_enable,
   input logic [7:0]  midrail_ramp_level,
   input logic        speaker_out_enable,
   input logic        hp_left_stage_enable,
   input logic        hp_right_stage_enable,
   input logic        thermal_sensor_enable,
   input logic        thermal_output_cutoff,
   input logic        outputs_disabled,
   input logic        first_input_a_amp_enable,
   input logic        second_input_a_amp_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   // Same-edge writes are excluded: they may legally change the enables
   sequence hot_s;
      thermal_sensor_enable && thermal_output_cutoff && over_temp && !reg_wr;
   endsequence
   sequence ramping_s;
      ref_ramp_enable ##1 ref_ramp_enable;
   endsequence
   a_onehot_decode: assert property (divider_onehot == 4'h1 << ref_divider_select)
      else $error("divider decode wrong");
   a_div_write: assert property (reg_wr && reg_addr == 8'h01 |=> ref_divider_select == $past(reg_wdata[2:1]))
      else $error("divider write lost");
   a_div_reset: assert property ($fell(sys_rst) |-> ref_divider_select == 2'h3)
      else $error("divider reset value wrong");
   a_ramp_step: assert property (ramping_s |-> (midrail_ramp_level - $past(midrail_ramp_level)) inside {8'h00, 8'h01})
      else $error("reference stepped");
   a_thermal_cut: assert property (hot_s |=> outputs_disabled)
      else $error("outputs not cut when hot");
   a_gate_outputs: assert property (outputs_disabled |-> !(speaker_out_enable || hp_left_stage_enable || hp_right_stage_enable))
      else $error("output left on when cut");
   a_sensor_gate: assert property (!thermal_sensor_enable |=> !outputs_disabled)
      else $error("cut without sensor");
   a_amp_write: assert property (reg_wr && reg_addr == 8'h02 |=> {first_input_a_amp_enable, second_input_a_amp_enable} == {$past(reg_wdata[7]), $past(reg_wdata[5])})
      else $error("amp enable write lost");
   a_div_hold: assert property (!(reg_wr && reg_addr == 8'h01) |=> $stable(ref_divider_select))
      else $error("divider changed without write");
endmodule : power_reference_control_regs_asserts
bind power_reference_control_regs power_reference_control_regs_asserts chk_i (
   .clk                       (clk),
   .sys_rst                   (sys_rst),
   .reg_wr                    (reg_wr),
   .reg_addr                  (reg_addr),
   .reg_wdata                 (reg_wdata),
   .over_temp                 (over_temp),
   .ref_divider_select        (ref_divider_select),
   .divider_onehot            (divider_onehot),
   .ref_ramp_enable           (ref_ramp_enable),
   .midrail_ramp_level        (midrail_ramp_level),
   .speaker_out_enable        (speaker_out_enable),
   .hp_left_stage_enable      (hp_left_stage_enable),
   .hp_right_stage_enable     (hp_right_stage_enable),
   .thermal_sensor_enable     (thermal_sensor_enable),
   .thermal_output_cutoff     (thermal_output_cutoff),
   .outputs_disabled          (outputs_disabled),
   .first_input_a_amp_enable  (first_input_a_amp_enable),
   .second_input_a_amp_enable (second_input_a_amp_enable)
);

/* power_reference_control_regs_test.sv */
// Self-checking bench for the power and reference control bank
`timescale 1ns/100ps
module power_reference_control_regs_test;
   logic clk = 0, sys_rst = 1, reg_wr = 0, over_temp = 0;
   logic [7:0] reg_addr = 8'h00, midrail_ramp_level;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [1:0] ref_divider_select;
   logic [3:0] divider_onehot;
   logic ref_ramp_enable, main_bias_enable, speaker_out_enable, hp_left_stage_enable, hp_right_stage_enable;
   logic thermal_sensor_enable, thermal_output_cutoff, outputs_disabled;
   logic first_input_a_amp_enable, first_input_b_amp_enable, second_input_a_amp_enable;
   int errors = 0, num_checks = 0, cyc = 0;
   power_reference_control_regs DUT (
      .clk                       (clk),
      .sys_rst                   (sys_rst),
      .reg_wr                    (reg_wr),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_rdata                 (reg_rdata),
      .over_temp                 (over_temp),
      .ref_divider_select        (ref_divider_select),
      .divider_onehot            (divider_onehot),
      .ref_ramp_enable           (ref_ramp_enable),
      .midrail_ramp_level        (midrail_ramp_level),
      .main_bias_enable          (main_bias_enable),
      .speaker_out_enable        (speaker_out_enable),
      .hp_left_stage_enable      (hp_left_stage_enable),
      .hp_right_stage_enable     (hp_right_stage_enable),
      .thermal_sensor_enable     (thermal_sensor_enable),
      .thermal_output_cutoff     (thermal_output_cutoff),
      .outputs_disabled          (outputs_disabled),
      .first_input_a_amp_enable  (first_input_a_amp_enable),
      .first_input_b_amp_enable  (first_input_b_amp_enable),
      .second_input_a_amp_enable (second_input_a_amp_enable)
   );
   ////////////////////////////////////////////////////////////
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      #1 reg_addr = a;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task report_and_stop;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // Whole run is under a thousand cycles; the ceiling leaves ample slack
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      #1 sys_rst = 0;
      rd(8'h01, 16'h0006);
      rd(8'h02, 16'h2000);
      rd(8'h39, 16'h0000);
      chk(16'({thermal_sensor_enable, thermal_output_cutoff, ref_divider_select, divider_onehot}), 16'h78);
      for (int i = 0; i < 4; i++) begin
         wr(8'h01, 16'(i * 2));
         rd(8'h01, 16'(i * 2));
         chk(16'(divider_onehot), 16'h1 << i);
      end
      wr(8'h01, 16'hffff);
      rd(8'h01, 16'h1307);
      wr(8'h10, 16'h0000);
      rd(8'h10, 16'h0000);
      rd(8'h01, 16'h1307);
      wr(8'h02, 16'h00a0);
      chk(16'({first_input_a_amp_enable, first_input_b_amp_enable, second_input_a_amp_enable}), 16'h5);
      wr(8'h02, 16'hffff);
      rd(8'h02, 16'h60e0);
      chk(16'({thermal_sensor_enable, thermal_output_cutoff}), 16'h3);
      @(posedge clk);
      #1 over_temp = 1;
      @(posedge clk);
      #1 chk(16'({outputs_disabled, speaker_out_enable, hp_left_stage_enable, hp_right_stage_enable}), 16'h8);
      rd(8'h02, 16'he0e0);
      wr(8'h02, 16'h2000);
      @(posedge clk);
      #1 chk(16'({outputs_disabled, speaker_out_enable, hp_left_stage_enable, hp_right_stage_enable}), 16'h7);
      over_temp = 0;
      wr(8'h39, 16'h0001);
      chk(16'(ref_ramp_enable), 16'h1);
      repeat (8) @(posedge clk);
      #1 chk(16'(midrail_ramp_level inside {[8'h01:8'h08]}), 16'h1);
      repeat (600) @(posedge clk);
      #1 chk(16'(midrail_ramp_level), 16'h00ff);
      wr(8'h01, 16'h0003);
      chk(16'({main_bias_enable, ref_ramp_enable, divider_onehot}), 16'h32);
      rd(8'h01, 16'h0003);
      wr(8'h01, 16'h0303);
      chk(16'({hp_left_stage_enable, hp_right_stage_enable, speaker_out_enable, main_bias_enable}), 16'hd);
      wr(8'h01, 16'h1303);
      chk(16'({hp_left_stage_enable, hp_right_stage_enable, speaker_out_enable, outputs_disabled}), 16'he);
      wr(8'h02, 16'h20c0);
      chk(16'({first_input_a_amp_enable, first_input_b_amp_enable, second_input_a_amp_enable}), 16'h6);
      wr(8'h02, 16'h0000);
      wr(8'h01, 16'h0000);
      wr(8'h39, 16'h0000);
      @(posedge clk);
      #1 chk(16'(midrail_ramp_level), 16'h0000);
      chk(16'({thermal_output_cutoff, main_bias_enable, ref_ramp_enable, speaker_out_enable}), 16'h0);
      chk(16'(divider_onehot), 16'h1);
      @(posedge clk);
      #1 sys_rst = 1;
      @(posedge clk);
      #1 sys_rst = 0;
      rd(8'h01, 16'h0006);
      chk(16'({thermal_sensor_enable, thermal_output_cutoff, divider_onehot}), 16'h18);
      report_and_stop();
   end
endmodule : power_reference_control_regs_test
